// ===== pmi_params.svh
`ifndef PMI_PARAMS_SVH
`define PMI_PARAMS_SVH

// Sub addresses reached over the two-wire serial port.
`define PMI_SUB_TEMP 8'h05
`define PMI_SUB_MASK 8'h06

// Field positions in the temperature status byte.
`define PMI_BIT_TEMP 0

// Field positions in the interrupt enable and boost request byte.
`define PMI_BIT_CHG_EN 7
`define PMI_BIT_FAULT_EN 6
`define PMI_BIT_PWR_EN 5
`define PMI_BIT_BOOST_EN 4
`define PMI_BIT_ILIM_EN 3
`define PMI_BIT_UVCL_EN 2
`define PMI_BIT_BOOST_REQ 1

// Reset value and writable bits of the enable byte.
`define PMI_MASK_RESET 8'h00
`define PMI_MASK_WRITABLE 8'hFE

// Serial slave address; the value is arbitrary.
`define PMI_DEV_ADDR 7'h2A

// Bits in one serial byte.
`define PMI_BYTE_BITS 4'h8

`endif

// ===== pmi_pkg.sv
package pmi_pkg;

   typedef enum logic [3:0] {
      PMI_IDLE = 4'b0000,
      PMI_ADDR = 4'b0001,
      PMI_AACK = 4'b0010,
      PMI_SUB = 4'b0011,
      PMI_SACK = 4'b0100,
      PMI_WR = 4'b0101,
      PMI_WACK = 4'b0110,
      PMI_RD = 4'b0111,
      PMI_MACK = 4'b1000
   } pmi_serial_e;

   typedef logic [3:0] pmi_group_t;

endpackage : pmi_pkg

// ===== pmi_grp_if.sv
`timescale 1ns/100ps
interface pmi_grp_if #(parameter int W = 4);
   logic [W-1:0] sig;
   logic en;
   logic hit;

   modport det (input sig, input en, output hit);
   modport top (output sig, output en, input hit);
endinterface : pmi_grp_if

// ===== pmi_sync.sv
`timescale 1ns/100ps
module pmi_sync #(parameter int W = 1) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : pmi_sync

// ===== pmi_chg_det.sv
`timescale 1ns/100ps
module pmi_chg_det import pmi_pkg::*; #(parameter int W = 4) (
   input wire logic clk,
   input wire logic resetn,
   pmi_grp_if.det grp
);

   logic [W-1:0] prev_r;
   logic [2:0] primed_r;

   // The synchroniser delivers real samples only from the second edge
   // after reset, so the history is trusted once it has stored one of
   // them; no spurious change is seen when the status inputs settle.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_r <= '0;
         primed_r <= 3'h0;
      end else begin
         prev_r <= grp.sig;
         primed_r <= {primed_r[1:0], 1'h1};
      end
   end

   assign grp.hit = grp.en & primed_r[2] & (grp.sig != prev_r); // [RQ11]

endmodule : pmi_chg_det

// ===== pmi_irq_mask.sv
// How it works
// [RQ1] Sub address 05 bit 0 flags temperature.
// [RQ2] Enable bit 7: charger state change interrupts.
// [RQ3] Enable bit 6: fault flag change interrupts.
// [RQ4] Enable bit 5: input power change interrupts.
// [RQ5] Enable bit 4: boost state or ID changes.
// [RQ6] Enable bit 3: input current limit changes.
// [RQ7] Enable bit 2: brownout limit changes.
// [RQ8] Any write to sub 06 clears pending.
// [RQ9] Bit 1 requests manual boost; resets zero.
// [RQ10] Boost blocked while USB or wall powered.
// [RQ11] Enabled change sets sticky pending interrupt.
// [RQ12] Host reads status, then writes mask byte.
`timescale 1ns/100ps
`include "pmi_params.svh"
module pmi_irq_mask import pmi_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = `PMI_DEV_ADDR
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic irqOut,
   output logic irqOe,
   input wire logic [2:0] chargerState,
   input wire logic overvoltageFault,
   input wire logic badCellFault,
   input wire logic boostOvercurrentFault,
   input wire logic thermistorHotFault,
   input wire logic usbInputValid,
   input wire logic wallInputValid,
   input wire logic extPowerPresent,
   input wire logic boostEnabledState,
   input wire logic idPinDetected,
   input wire logic inputLimitActive,
   input wire logic brownoutLimitActive,
   input wire logic tempOutOfChargeRange,
   input wire logic idAutoBoostLockout,
   input wire logic usbVoltageApplied,
   input wire logic wallVoltageApplied,
   output logic boostEnable
);

   localparam int NSYNC = 20;
   localparam int NGRP = 6;

   // Synchronised copies of every pin and status input.
   logic [NSYNC-1:0] rawIn;
   logic [NSYNC-1:0] syncOut;
   logic sclS;
   logic sdaS;
   logic wallAppS;
   logic usbAppS;
   logic lockoutS;
   logic tempS;
   logic brownS;
   logic ilimS;
   logic idS;
   logic boostStS;
   logic extS;
   logic wallS;
   logic usbS;
   logic hotS;
   logic boostFltS;
   logic badCellS;
   logic ovS;
   logic [2:0] chgS;

   // The bus lines pass inverted, so the synchroniser's reset state is
   // the idle high bus and no false edge follows reset.
   assign rawIn = {~sclIn, ~sdaIn, wallVoltageApplied, usbVoltageApplied,
      idAutoBoostLockout, tempOutOfChargeRange, brownoutLimitActive,
      inputLimitActive, idPinDetected, boostEnabledState, extPowerPresent,
      wallInputValid, usbInputValid, thermistorHotFault,
      boostOvercurrentFault, badCellFault, overvoltageFault, chargerState};

   pmi_sync #(.W(NSYNC)) uSync (
      .clk(clk),
      .resetn(resetn),
      .d(rawIn),
      .q(syncOut)
   );

   assign {sclS, sdaS, wallAppS, usbAppS, lockoutS, tempS, brownS, ilimS,
      idS, boostStS, extS, wallS, usbS, hotS, boostFltS, badCellS, ovS,
      chgS} = syncOut ^ 20'hC0000;

   // Serial slave state.
   pmi_serial_e state_r;
   pmi_serial_e state_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   logic [7:0] sub_r;
   logic [7:0] sub_nxt;
   logic sdaOe_r;
   logic sdaOe_nxt;
   logic rw_r;
   logic rw_nxt;
   logic nack_r;
   logic nack_nxt;
   logic sclPrev_r;
   logic sdaPrev_r;

   // Register file and interrupt state.
   logic [7:0] mask_r;
   logic [7:0] mask_nxt;
   logic pending_r;
   logic pending_nxt;
   logic boostEnable_r;
   logic boostEnable_nxt;

   wire sclRise = sclS & ~sclPrev_r;
   wire sclFall = ~sclS & sclPrev_r;
   wire startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
   wire stopCond = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
   wire byteDone = (cnt_r == `PMI_BYTE_BITS);
   wire rxState = (state_r == PMI_ADDR) | (state_r == PMI_SUB) |
      (state_r == PMI_WR);
   wire regWr = sclFall & (state_r == PMI_WR) & byteDone;
   wire maskWr = regWr & (sub_r == `PMI_SUB_MASK);
   wire selTemp = (sub_r == `PMI_SUB_TEMP);
   wire selMask = (sub_r == `PMI_SUB_MASK);
   wire [7:0] tempByte = {7'h00, tempS}; // [RQ1]
   wire [7:0] rdData = selTemp ? tempByte :
      (selMask ? mask_r : 8'h00);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      sub_nxt = sub_r;
      sdaOe_nxt = sdaOe_r;
      rw_nxt = rw_r;
      nack_nxt = nack_r;
      if (startCond) begin
         state_nxt = PMI_ADDR;
         cnt_nxt = 4'h0;
         sdaOe_nxt = 1'b0;
      end else if (stopCond) begin
         state_nxt = PMI_IDLE;
         sdaOe_nxt = 1'b0;
      end else if (sclRise) begin
         if (state_r == PMI_RD) begin
            cnt_nxt = cnt_r + 4'h1;
         end else if (state_r == PMI_MACK) begin
            nack_nxt = sdaS;
         end else if (rxState) begin
            sh_nxt = {sh_r[6:0], sdaS};
            cnt_nxt = cnt_r + 4'h1;
         end
      end else if (sclFall) begin
         unique case (state_r)
            PMI_IDLE: begin
               state_nxt = PMI_IDLE;
            end
            PMI_ADDR: begin
               if (byteDone) begin
                  if (sh_r[7:1] == DEV_ADDR) begin
                     rw_nxt = sh_r[0];
                     sdaOe_nxt = 1'b1;
                     state_nxt = PMI_AACK;
                  end else begin
                     state_nxt = PMI_IDLE;
                  end
               end
            end
            PMI_AACK: begin
               cnt_nxt = 4'h0;
               if (rw_r) begin
                  sh_nxt = rdData;
                  sdaOe_nxt = ~rdData[7];
                  state_nxt = PMI_RD;
               end else begin
                  sdaOe_nxt = 1'b0;
                  state_nxt = PMI_SUB;
               end
            end
            PMI_SUB: begin
               if (byteDone) begin
                  sub_nxt = sh_r;
                  sdaOe_nxt = 1'b1;
                  state_nxt = PMI_SACK;
               end
            end
            PMI_SACK: begin
               sdaOe_nxt = 1'b0;
               cnt_nxt = 4'h0;
               state_nxt = PMI_WR;
            end
            PMI_WR: begin
               if (byteDone) begin
                  sdaOe_nxt = 1'b1;
                  state_nxt = PMI_WACK;
               end
            end
            PMI_WACK: begin
               sdaOe_nxt = 1'b0;
               cnt_nxt = 4'h0;
               sub_nxt = sub_r + 8'h01;
               state_nxt = PMI_WR;
            end
            PMI_RD: begin
               if (byteDone) begin
                  sdaOe_nxt = 1'b0;
                  sub_nxt = sub_r + 8'h01;
                  state_nxt = PMI_MACK;
               end else begin
                  sdaOe_nxt = ~sh_r[6];
                  sh_nxt = {sh_r[6:0], 1'b0};
               end
            end
            PMI_MACK: begin
               if (nack_r) begin
                  state_nxt = PMI_IDLE;
               end else begin
                  sh_nxt = rdData;
                  sdaOe_nxt = ~rdData[7];
                  cnt_nxt = 4'h0;
                  state_nxt = PMI_RD;
               end
            end
            default: begin
               state_nxt = PMI_IDLE;
               sdaOe_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= PMI_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         sub_r <= 8'h00;
         sdaOe_r <= 1'b0;
         rw_r <= 1'b0;
         nack_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         sub_r <= sub_nxt;
         sdaOe_r <= sdaOe_nxt;
         rw_r <= rw_nxt;
         nack_r <= nack_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclPrev_r <= sclS;
         sdaPrev_r <= sdaS;
      end
   end

   // Enable byte; bit 0 is not implemented and reads as zero.
   assign mask_nxt = maskWr ? (sh_r & `PMI_MASK_WRITABLE) : mask_r; // [RQ9]

   // Change detectors, one per enable bit, highest bit first.
   pmi_group_t grpSig [NGRP];
   logic [NGRP-1:0] grpHit;

   assign grpSig[0] = {1'b0, chgS}; // [RQ2]
   assign grpSig[1] = {ovS, badCellS, boostFltS, hotS}; // [RQ3]
   assign grpSig[2] = {1'b0, usbS, wallS, extS}; // [RQ4]
   assign grpSig[3] = {2'b00, boostStS, idS}; // [RQ5]
   assign grpSig[4] = {3'b000, ilimS}; // [RQ6]
   assign grpSig[5] = {3'b000, brownS}; // [RQ7]

   for (genvar i = 0; i < NGRP; i++) begin : gGrp
      pmi_grp_if #(.W(4)) grp ();
      assign grp.sig = grpSig[i];
      assign grp.en = mask_r[`PMI_BIT_CHG_EN - i];
      assign grpHit[i] = grp.hit;
      pmi_chg_det #(.W(4)) uDet (
         .clk(clk),
         .resetn(resetn),
         .grp(grp.det)
      );
   end

   // A change in the same cycle as a clearing write keeps the request.
   assign pending_nxt = (|grpHit) | (pending_r & ~maskWr); // [RQ8] [RQ11]

   // Manual request forces the boost on; otherwise the ID pin starts it
   // unless locked out. Either way applied input power blocks it.
   wire boostWanted = mask_r[`PMI_BIT_BOOST_REQ] |
      (~lockoutS & idS); // [RQ9]
   assign boostEnable_nxt = boostWanted & ~usbAppS & ~wallAppS; // [RQ10]

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mask_r <= `PMI_MASK_RESET;
         pending_r <= 1'b0;
         boostEnable_r <= 1'b0;
      end else begin
         mask_r <= mask_nxt;
         pending_r <= pending_nxt;
         boostEnable_r <= boostEnable_nxt;
      end
   end

   // Both pins are open drain: they only ever pull low.
   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_r;
   assign irqOut = 1'b0;
   assign irqOe = pending_r; // [RQ11]
   assign boostEnable = boostEnable_r;

endmodule : pmi_irq_mask

// ===== pmi_irq_mask_monitor.sv
`timescale 1ns/100ps
module pmi_irq_mask_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sclIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic irqOut,
   input wire logic irqOe,
   input wire logic idPinDetected,
   input wire logic idAutoBoostLockout,
   input wire logic usbVoltageApplied,
   input wire logic wallVoltageApplied,
   input wire logic boostEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_RST_IDLE: assert property (disable iff (1'h0)
      !resetn |-> !boostEnable && !irqOe) else $error("active in reset");
   AST_USB_BLOCK: assert property (
      usbVoltageApplied [*5] |=> !boostEnable) else $error("boost on usb");
   AST_WALL_BLOCK: assert property (
      wallVoltageApplied [*5] |=> !boostEnable) else $error("boost on wall");
   AST_AUTO_BOOST: assert property (
      (!usbVoltageApplied && !wallVoltageApplied && idPinDetected &&
      !idAutoBoostLockout) [*5] |=> boostEnable) else $error("no auto boost");
   AST_IRQ_STICKY: assert property (
      irqOe && sclIn |=> irqOe) else $error("irq dropped early");
   AST_IRQ_CLEAR: assert property (
      $fell(irqOe) |-> $rose(sdaOe)) else $error("irq clear untimed");
   AST_SDA_EDGE: assert property (
      $changed(sdaOe) |-> $past(sclIn, 4) && !$past(sclIn, 3))
      else $error("sda moved off scl fall");
   AST_OPEN_DRAIN: assert property (
      sdaOut == 1'h0 && irqOut == 1'h0) else $error("pin driven high");
endmodule : pmi_irq_mask_monitor
bind pmi_irq_mask pmi_irq_mask_monitor MON (.clk(clk), .resetn(resetn),
   .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .irqOut(irqOut),
   .irqOe(irqOe), .idPinDetected(idPinDetected),
   .idAutoBoostLockout(idAutoBoostLockout),
   .usbVoltageApplied(usbVoltageApplied),
   .wallVoltageApplied(wallVoltageApplied), .boostEnable(boostEnable));

// ===== pmi_host_model.sv
`timescale 1ns/100ps
`include "pmi_params.svh"
module pmi_host_model (
   input wire logic clk,
   input wire logic sdaOe,
   output logic scl,
   output logic sda
);
   logic drv = 1'h1;
   // The line has a pull-up, so a released line reads high.
   assign sda = drv & ~sdaOe;
   initial scl = 1'h1;
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : wt
   task automatic bit1(input logic b, output logic r);
      drv = b;
      wt(4);
      scl = 1'h1;
      wt(4);
      r = sda;
      scl = 1'h0;
      wt(4);
   endtask : bit1
   task automatic start;
      drv = 1'h1;
      wt(4);
      scl = 1'h1;
      wt(4);
      drv = 1'h0;
      wt(4);
      scl = 1'h0;
      wt(4);
   endtask : start
   task automatic xfer(input logic [7:0] d, input logic m9,
      output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
      bit1(m9, a);
   endtask : xfer
   task automatic stop;
      drv = 1'h0;
      wt(4);
      scl = 1'h1;
      wt(4);
      drv = 1'h1;
      wt(4);
   endtask : stop
   task automatic wr(input logic [7:0] s, d, output logic nk);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      xfer({`PMI_DEV_ADDR, 1'h0}, 1'h1, q, a0);
      xfer(s, 1'h1, q, a1);
      xfer(d, 1'h1, q, a2);
      stop();
      nk = a0 | a1 | a2;
   endtask : wr
   task automatic rd(input logic [7:0] s, output logic [7:0] d,
      output logic nk);
      logic [7:0] q;
      logic a0, a1, a2, a3;
      start();
      xfer({`PMI_DEV_ADDR, 1'h0}, 1'h1, q, a0);
      xfer(s, 1'h1, q, a1);
      start();
      xfer({`PMI_DEV_ADDR, 1'h1}, 1'h1, q, a2);
      xfer(8'hFF, 1'h1, d, a3);
      stop();
      nk = a0 | a1 | a2;
   endtask : rd
endmodule : pmi_host_model

// ===== pmi_irq_mask_bench.sv
`timescale 1ns/100ps
`include "pmi_params.svh"
module pmi_irq_mask_bench;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic [13:0] st = '0;
   logic tempOut = 1'h0;
   logic lock = 1'h1;
   logic usbV = 1'h0;
   logic wallV = 1'h0;
   logic scl, sda, sdaOut, sdaOe, irqOut, irqOe, boostEnable;
   int miscompares = 0;
   int totalChecks = 0;
   int cyc = 0;
   pmi_host_model h (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sda(sda));
   pmi_irq_mask DUT (.clk(clk), .resetn(resetn), .sclIn(scl),
      .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .irqOut(irqOut),
      .irqOe(irqOe), .chargerState(st[13:11]), .overvoltageFault(st[10]),
      .badCellFault(st[9]), .boostOvercurrentFault(st[8]),
      .thermistorHotFault(st[7]), .usbInputValid(st[6]),
      .wallInputValid(st[5]), .extPowerPresent(st[4]),
      .boostEnabledState(st[3]), .idPinDetected(st[2]),
      .inputLimitActive(st[1]), .brownoutLimitActive(st[0]),
      .tempOutOfChargeRange(tempOut), .idAutoBoostLockout(lock),
      .usbVoltageApplied(usbV), .wallVoltageApplied(wallV),
      .boostEnable(boostEnable));
   initial forever #25 clk = ~clk;
   task automatic finalReport;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finalReport
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         finalReport();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : wt
   task automatic chk(input string n, input logic [7:0] s, e);
      totalChecks++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic tReset;
      logic [7:0] d;
      logic nk;
      h.rd(`PMI_SUB_MASK, d, nk);
      chk("mask", d, `PMI_MASK_RESET);
      chk("nak", {7'h0, nk}, 8'h00);
      chk("boost", {7'h0, boostEnable}, 8'h00);
      $display("reset test done");
   endtask : tReset
   task automatic tTemp;
      logic [7:0] d;
      logic nk;
      for (int v = 0; v < 2; v++) begin
         tempOut = v[0];
         h.wr(`PMI_SUB_TEMP, 8'hFF, nk);
         h.rd(`PMI_SUB_TEMP, d, nk);
         chk("temp", d, {7'h0, v[0]});
      end
      $display("temperature test done");
   endtask : tTemp
   task automatic tGroups;
      logic [7:0] d;
      logic [7:0] g;
      logic nk;
      for (int i = 0; i < 14; i++) begin
         g = i > 10 ? 8'h80 : i > 6 ? 8'h40 : i > 3 ? 8'h20 :
            i > 1 ? 8'h10 : i == 1 ? 8'h08 : 8'h04;
         h.wr(`PMI_SUB_MASK, 8'hFC & ~g, nk);
         st[i] = ~st[i];
         wt(6);
         chk("masked", {7'h0, irqOe}, 8'h00);
         h.wr(`PMI_SUB_MASK, g, nk);
         st[i] = ~st[i];
         wt(6);
         chk("irq", {7'h0, irqOe}, 8'h01);
         h.rd(`PMI_SUB_MASK, d, nk);
         chk("readback", d, g);
         chk("sticky", {7'h0, irqOe}, 8'h01);
         h.wr(`PMI_SUB_MASK, i[0] ? g : 8'h00, nk);
         chk("clear", {7'h0, irqOe}, 8'h00);
      end
      $display("group test done");
   endtask : tGroups
   task automatic tBoost;
      logic [7:0] d;
      logic nk;
      h.wr(`PMI_SUB_MASK, 8'hFF, nk);
      h.rd(`PMI_SUB_MASK, d, nk);
      chk("writable", d, `PMI_MASK_WRITABLE);
      for (int k = 0; k < 4; k++) begin
         {wallV, usbV} = k[1:0];
         wt(5);
         chk("manual", {7'h0, boostEnable}, {7'h0, k == 0});
      end
      {wallV, usbV} = 2'h0;
      h.wr(`PMI_SUB_MASK, 8'h00, nk);
      chk("off", {7'h0, boostEnable}, 8'h00);
      st[2] = 1'h1;
      lock = 1'h0;
      wt(5);
      chk("auto", {7'h0, boostEnable}, 8'h01);
      usbV = 1'h1;
      wt(5);
      chk("auto usb", {7'h0, boostEnable}, 8'h00);
      usbV = 1'h0;
      lock = 1'h1;
      wt(5);
      chk("locked", {7'h0, boostEnable}, 8'h00);
      st[2] = 1'h0;
      $display("boost test done");
   endtask : tBoost
   task automatic tRefused;
      logic [7:0] d;
      logic nk;
      h.wr(`PMI_SUB_MASK, 8'h08, nk);
      st[1] = ~st[1];
      wt(6);
      h.wr(8'h07, 8'hFF, nk);
      chk("other sub", {7'h0, irqOe}, 8'h01);
      h.rd(8'h07, d, nk);
      chk("unmapped", d, 8'h00);
      h.rd(`PMI_SUB_MASK, d, nk);
      chk("kept", d, 8'h08);
      h.wr(`PMI_SUB_MASK, 8'h00, nk);
      chk("cleared", {7'h0, irqOe}, 8'h00);
      $display("refused access test done");
   endtask : tRefused
   task automatic tMidReset;
      logic [7:0] d;
      logic nk;
      h.wr(`PMI_SUB_MASK, 8'h80, nk);
      st[13] = ~st[13];
      wt(6);
      chk("pending", {7'h0, irqOe}, 8'h01);
      resetn = 1'h0;
      wt(2);
      resetn = 1'h1;
      wt(4);
      chk("irq reset", {7'h0, irqOe}, 8'h00);
      h.rd(`PMI_SUB_MASK, d, nk);
      chk("mask reset", d, `PMI_MASK_RESET);
      $display("mid reset test done");
   endtask : tMidReset
   initial begin
      wt(8);
      resetn = 1'h1;
      wt(4);
      tReset();
      tTemp();
      tGroups();
      tBoost();
      tRefused();
      tMidReset();
      finalReport();
   end
endmodule : pmi_irq_mask_bench
